// ==== mhc_pkg.sv ====
// Package for the motor halt control block: parameter map, types and timing
package mhc_pkg;

   // ==================================================================
   // Parameter addresses
   localparam logic [15:0] ADDR_DECEL    = 16'h0616;
   localparam logic [15:0] ADDR_HALTTYPE = 16'h062e;
   localparam logic [15:0] ADDR_CURLIM   = 16'h110c;

   // ==================================================================
   // Reset values and legal ranges
   localparam logic [31:0] DECEL_RST     = 32'h0000_02ee;
   localparam logic [31:0] DECEL_MIN     = 32'h0000_02ee;
   localparam logic [31:0] DECEL_MAX     = 32'h002d_c6c0;
   localparam logic [15:0] TYPE_RAMP     = 16'h0001;
   localparam logic [15:0] TYPE_CURRENT  = 16'h0003;
   localparam logic [15:0] HALTTYPE_RST  = 16'h0003;
   localparam logic [15:0] CURLIM_RST    = 16'h0064;

   // ==================================================================
   // Timing
   localparam int CLK_MHZ        = 50;
   localparam int STILL_TIME_US  = 2;
   localparam int STILL_CYCLES   = STILL_TIME_US * CLK_MHZ;
   localparam logic [31:0] STILL_SPEED = 32'h0000_0002;

   // ==================================================================
   // Halt sequencer states, one-hot
   typedef enum logic [5:0] {
      ST_RUN    = 6'h01,
      ST_BRAKE  = 6'h02,
      ST_ADJUST = 6'h04,
      ST_HOLD   = 6'h08,
      ST_RESUME = 6'h10,
      ST_FAULT  = 6'h20
   } mhc_state_t;

   // ==================================================================
   // Parameter access carriers
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [31:0] wdata;
   } mhc_param_req_t;

   typedef struct packed {
      logic        ack;
      logic        err;
      logic [31:0] rdata;
   } mhc_param_rsp_t;

endpackage : mhc_pkg

// ==== mhc_sync2.sv ====
// Two-stage synchroniser for one asynchronous level
`timescale 1ns/1ps
module mhc_sync2
   import mhc_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic resetn,
   // Level in and out
   input  wire logic asyncIn,
   output logic      syncOut
);

   logic metaQ;

   // First stage is read only by the second
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         metaQ   <= 1'b0;
         syncOut <= 1'b0;
      end else begin
         metaQ   <= asyncIn;
         syncOut <= metaQ;
      end
   end

endmodule : mhc_sync2

// ==== mhc_standstill.sv ====
// Standstill detector: speed inside a band for a settle time
`timescale 1ns/1ps
module mhc_standstill
   import mhc_pkg::*;
#(
   parameter int          CYCLES = STILL_CYCLES,
   parameter logic [31:0] BAND   = STILL_SPEED
)
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // Measured speed, same clock domain
   input  wire logic [31:0] speed,
   // Standstill flag
   output logic             still
);

   localparam logic [15:0] LAST = 16'(CYCLES - 1);

   logic [15:0] cntQ;
   logic [31:0] mag;
   logic        inBand;

   // Magnitude of signed speed
   assign mag    = speed[31] ? (~speed + 32'h0000_0001) : speed;
   assign inBand = (mag <= BAND);

   // Settle counter; a blip out of band restarts it
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cntQ  <= 16'h0000;
         still <= 1'b0;
      end else if (!inBand) begin
         cntQ  <= 16'h0000;
         still <= 1'b0;
      end else if (cntQ >= LAST) begin
         still <= 1'b1;
      end else begin
         cntQ  <= cntQ + 16'h0001;
      end
   end

endmodule : mhc_standstill

// ==== mhc_motor_halt_control.sv ====
// Motor halt control: halt sequencer, braking selection and halt parameters
// What this block does
// RL1 - An active halt request brakes the motor to standstill and suspends, not drops, the move.
// RL2 - At standstill the position is adjusted once, position control holds, stage stays enabled.
// RL3 - The suspended move resumes only when no halt request from any source remains.
// RL4 - Requests withdrawn during braking still let braking finish before accelerating again.
// RL5 - A halt request from the host or from the signal input alone is enough.
// RL6 - The braking type selects ramp braking with 1 and current braking with 3, resetting to 3.
// RL7 - Ramp braking uses the profile deceleration, 750 to 3000000 rpm/s, default 750.
// RL8 - Current braking is limited to the halt current limit in 0.01 A steps, also at mode end.
// RL9 - Ramp braking is only used in profile-generator modes, otherwise current braking.
// RL10 - DC bus overvoltage during braking disables the stage and raises an error; motor coasts.
// RL11 - The configurer should size the current limit so standstill comes at the wanted rate.
// RL12 - Writes of a braking type other than 1 or 3 are refused and the old value is kept.
`timescale 1ns/1ps
module mhc_motor_halt_control
   import mhc_pkg::*;
#(
   parameter logic [15:0] CURLIM_DEFAULT = CURLIM_RST
)
(
   // Clock and reset
   input  wire logic           clk,
   input  wire logic           resetn,
   // Parameter access over the fieldbus
   input  wire mhc_param_req_t paramReq,
   output mhc_param_rsp_t      paramRsp,
   // Halt request sources
   input  wire logic           haltHost,
   input  wire logic           haltPin,
   // Drive context
   input  wire logic           profileMode,
   input  wire logic           modeEnding,
   input  wire logic [31:0]    speed,
   input  wire logic           dcBusOverPin,
   input  wire logic           faultClear,
   // Motion control outputs
   output logic                haltActive,
   output logic                brakeRamp,
   output logic                brakeCurrent,
   output logic [31:0]         decelSetpoint,
   output logic [15:0]         currentLimit,
   output logic                currentLimitOn,
   output logic                posAdjust,
   output logic                posHold,
   output logic                moveResume,
   output logic                stageEnable,
   output logic                dcBusOverErr
);

   // ==================================================================
   // Signals
   mhc_state_t  stateQ, stateD;
   logic [31:0] decelQ;
   logic [15:0] haltTypeQ;
   logic [15:0] curLimQ;
   logic        haltPinSync;
   logic        overSync;
   logic        still;
   logic        haltAny;
   logic        useRamp;
   logic        typeOk;
   logic        decelOk;
   logic        wrDecel, wrType, wrCur;

   // ==================================================================
   // Input conditioning
   mhc_sync2 uSyncHalt (
      .clk     (clk),
      .resetn  (resetn),
      .asyncIn (haltPin),
      .syncOut (haltPinSync)
   );

   mhc_sync2 uSyncOver (
      .clk     (clk),
      .resetn  (resetn),
      .asyncIn (dcBusOverPin),
      .syncOut (overSync)
   );

   mhc_standstill uStill (
      .clk    (clk),
      .resetn (resetn),
      .speed  (speed),
      .still  (still)
   );

   // Any single source is enough to halt
   assign haltAny = haltHost | haltPinSync; // RL5

   // Ramp only where a profile generator exists
   assign useRamp = (haltTypeQ == TYPE_RAMP) && profileMode; // RL9

   // ==================================================================
   // Parameter writes
   assign typeOk  = (paramReq.wdata[15:0] == TYPE_RAMP) ||
                    (paramReq.wdata[15:0] == TYPE_CURRENT); // RL12
   assign decelOk = (paramReq.wdata >= DECEL_MIN) && (paramReq.wdata <= DECEL_MAX); // RL7
   assign wrDecel = paramReq.wr && (paramReq.addr == ADDR_DECEL) && decelOk;
   assign wrType  = paramReq.wr && (paramReq.addr == ADDR_HALTTYPE) && typeOk;
   assign wrCur   = paramReq.wr && (paramReq.addr == ADDR_CURLIM);

   // Profile deceleration
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         decelQ <= DECEL_RST; // RL7
      end else if (wrDecel) begin
         decelQ <= paramReq.wdata;
      end
   end

   // Braking type; illegal codes leave it as it was
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         haltTypeQ <= HALTTYPE_RST; // RL6
      end else if (wrType) begin
         haltTypeQ <= paramReq.wdata[15:0]; // RL12
      end
   end

   // Halt current limit, 0.01 A peak per step
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         curLimQ <= CURLIM_DEFAULT;
      end else if (wrCur) begin
         curLimQ <= paramReq.wdata[15:0]; // RL8
      end
   end

   // Response: one-cycle ack, error on any unmapped access or refused write
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         paramRsp <= '0;
      end else begin
         paramRsp.ack   <= paramReq.wr | paramReq.rd;
         paramRsp.err   <= 1'b0;
         paramRsp.rdata <= 32'h0000_0000;
         unique case (paramReq.addr)
            ADDR_DECEL: begin
               paramRsp.rdata <= decelQ;
               paramRsp.err   <= paramReq.wr & ~decelOk;
            end
            ADDR_HALTTYPE: begin
               paramRsp.rdata <= {16'h0000, haltTypeQ};
               paramRsp.err   <= paramReq.wr & ~typeOk; // RL12
            end
            ADDR_CURLIM: begin
               paramRsp.rdata <= {16'h0000, curLimQ};
            end
            default: begin
               paramRsp.err   <= paramReq.wr | paramReq.rd;
            end
         endcase
      end
   end

   // ==================================================================
   // Halt sequencer
   always_comb begin
      stateD = stateQ;
      unique case (stateQ)
         ST_RUN: begin
            if (overSync) stateD = ST_FAULT;
            else if (haltAny) stateD = ST_BRAKE; // RL1
         end
         ST_BRAKE: begin
            // Keeps braking even if requests vanish
            if (overSync) stateD = ST_FAULT; // RL10
            else if (still) stateD = ST_ADJUST; // RL4
         end
         ST_ADJUST: begin
            if (overSync) stateD = ST_FAULT;
            else if (haltAny) stateD = ST_HOLD; // RL2
            else stateD = ST_RESUME; // RL4
         end
         ST_HOLD: begin
            if (overSync) stateD = ST_FAULT;
            else if (!haltAny) stateD = ST_RESUME; // RL3
         end
         ST_RESUME: begin
            if (overSync) stateD = ST_FAULT;
            else if (haltAny) stateD = ST_BRAKE;
            else stateD = ST_RUN;
         end
         ST_FAULT: begin
            // Stays off until cleared with the bus back in range
            if (faultClear && !overSync) stateD = ST_RUN;
         end
         default: stateD = ST_FAULT;
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stateQ <= ST_RUN;
      end else begin
         stateQ <= stateD;
      end
   end

   // ==================================================================
   // Registered outputs, decoded from the next state
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         haltActive   <= 1'b0;
         brakeRamp    <= 1'b0;
         brakeCurrent <= 1'b0;
         posAdjust    <= 1'b0;
         posHold      <= 1'b0;
         moveResume   <= 1'b0;
         stageEnable  <= 1'b1;
      end else begin
         haltActive   <= (stateD == ST_BRAKE) || (stateD == ST_ADJUST) ||
                         (stateD == ST_HOLD); // RL1
         brakeRamp    <= (stateD == ST_BRAKE) && useRamp; // RL9
         brakeCurrent <= (stateD == ST_BRAKE) && !useRamp; // RL9
         posAdjust    <= (stateD == ST_ADJUST); // RL2
         posHold      <= (stateD == ST_ADJUST) || (stateD == ST_HOLD); // RL2
         moveResume   <= (stateD == ST_RESUME); // RL3
         stageEnable  <= (stateD != ST_FAULT); // RL10
      end
   end

   // Setpoints handed to the profile and current loops
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         decelSetpoint  <= DECEL_RST;
         currentLimit   <= CURLIM_DEFAULT;
         currentLimitOn <= 1'b0;
      end else begin
         decelSetpoint  <= decelQ; // RL7
         currentLimit   <= curLimQ; // RL8
         currentLimitOn <= ((stateD == ST_BRAKE) && !useRamp) || modeEnding; // RL8
      end
   end

   // Overvoltage error flag, set wins over clear
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dcBusOverErr <= 1'b0;
      end else if (overSync && stateQ != ST_FAULT) begin
         dcBusOverErr <= 1'b1; // RL10
      end else if (faultClear && !overSync) begin
         dcBusOverErr <= 1'b0;
      end
   end

   // ==================================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   chk_halt_brakes: assert property ( // RL1
      (stateQ == ST_RUN) && haltHost && !overSync |=> haltActive && (stateQ == ST_BRAKE))
      else $error("halt request did not start braking");

   chk_pin_source: assert property ( // RL5
      (stateQ == ST_RUN) && haltPinSync && !overSync |=> (stateQ == ST_BRAKE))
      else $error("pin halt request ignored");

   chk_adjust_hold: assert property ( // RL2
      (stateQ == ST_BRAKE) && still && !overSync ##1 haltAny && !overSync
      |=> posHold && stageEnable && (stateQ == ST_HOLD))
      else $error("standstill did not lead to enabled hold");

   chk_adjust_pulse: assert property ( // RL2
      (stateQ == ST_ADJUST) |-> posAdjust ##1 !posAdjust)
      else $error("position adjust not a single pulse");

   chk_resume_clear: assert property ( // RL3
      $rose(moveResume) |-> !$past(haltAny))
      else $error("resumed with a halt pending");

   chk_brake_finish: assert property ( // RL4
      (stateQ == ST_BRAKE) && !still && !overSync |=> (stateQ == ST_BRAKE) && !moveResume)
      else $error("braking cut short");

   chk_type_legal: assert property ( // RL6
      (haltTypeQ == TYPE_RAMP) || (haltTypeQ == TYPE_CURRENT))
      else $error("braking type holds an illegal code");

   chk_reject_type: assert property ( // RL12
      paramReq.wr && (paramReq.addr == ADDR_HALTTYPE) && !typeOk
      |=> $stable(haltTypeQ) && paramRsp.err)
      else $error("illegal braking type accepted");

   chk_ramp_mode: assert property ( // RL9
      brakeRamp |-> $past(profileMode) && !brakeCurrent)
      else $error("ramp braking outside profile mode");

   chk_current_limit: assert property ( // RL8
      brakeCurrent |-> currentLimitOn)
      else $error("current braking without limit");

   chk_over_disable: assert property ( // RL10
      overSync && (stateQ == ST_BRAKE) |=> !stageEnable && dcBusOverErr [*2])
      else $error("overvoltage did not disable the stage");

   cov_halt_resume: cover property (
      (stateQ == ST_HOLD) ##1 (stateQ == ST_RESUME) ##1 (stateQ == ST_RUN));
   cov_early_clear: cover property (
      (stateQ == ST_BRAKE) && !haltAny ##1 (stateQ == ST_ADJUST));
   cov_ramp_brake: cover property (brakeRamp);
   cov_overvolt: cover property ((stateQ == ST_BRAKE) ##1 (stateQ == ST_FAULT));

endmodule : mhc_motor_halt_control

// ==== mhc_motor_model.sv ====
// Behavioural motor and power stage giving speed feedback to the halt block
`timescale 1ns/1ps
module mhc_motor_model
   import mhc_pkg::*;
#(
   parameter logic [31:0] RUN_SPEED = 32'h0000_03e8
)
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // Drive commands from the halt block
   input  wire logic        brakeRamp,
   input  wire logic        brakeCurrent,
   input  wire logic        posHold,
   input  wire logic        stageEnable,
   // Speed feedback
   output logic [31:0]      speed
);
   logic [31:0] speed_q;

   // ==================================================================
   // Speed: ramp brakes slower than current so both paths take time
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         speed_q <= RUN_SPEED;
      end else if (!stageEnable) begin
         speed_q <= (speed_q > 32'h0000_0000) ? speed_q - 32'h0000_0001 : speed_q; // Coasting
      end else if (posHold) begin
         speed_q <= 32'h0000_0000;
      end else if (brakeRamp) begin
         speed_q <= (speed_q > 32'h0000_0032) ? speed_q - 32'h0000_0032 : 32'h0000_0000;
      end else if (brakeCurrent) begin
         speed_q <= (speed_q > 32'h0000_0064) ? speed_q - 32'h0000_0064 : 32'h0000_0000;
      end else begin
         speed_q <= RUN_SPEED;
      end
   end

   assign speed = speed_q;

endmodule : mhc_motor_model

// ==== mhc_testbench.sv ====
// Self-checking testbench for the motor halt control block
`timescale 1ns/1ps
module testbench
   import mhc_pkg::*;
;
   logic           clk = 1'b0;
   logic           resetn = 1'b0;
   mhc_param_req_t req;
   mhc_param_rsp_t rsp;
   logic           haltHost, haltPin, profileMode, modeEnding, dcBusOverPin, faultClear;
   logic [31:0]    speed, decelSetpoint;
   logic [15:0]    currentLimit;
   logic           haltActive, brakeRamp, brakeCurrent, currentLimitOn, posAdjust;
   logic           posHold, moveResume, stageEnable, dcBusOverErr;
   int             badCount = 0;
   int             compares = 0;
   int             cycles = 0;
   logic [31:0]    dec, cl;
   logic [15:0]    badTypes [4];

   // ==================================================================
   // Design, motor model and clock
   mhc_motor_halt_control mhc_motor_halt_control_inst (
      .clk(clk), .resetn(resetn), .paramReq(req), .paramRsp(rsp),
      .haltHost(haltHost), .haltPin(haltPin), .profileMode(profileMode),
      .modeEnding(modeEnding), .speed(speed), .dcBusOverPin(dcBusOverPin),
      .faultClear(faultClear), .haltActive(haltActive), .brakeRamp(brakeRamp),
      .brakeCurrent(brakeCurrent), .decelSetpoint(decelSetpoint),
      .currentLimit(currentLimit), .currentLimitOn(currentLimitOn),
      .posAdjust(posAdjust), .posHold(posHold), .moveResume(moveResume),
      .stageEnable(stageEnable), .dcBusOverErr(dcBusOverErr));

   mhc_motor_model mhc_motor_model_inst (
      .clk(clk), .resetn(resetn), .brakeRamp(brakeRamp), .brakeCurrent(brakeCurrent),
      .posHold(posHold), .stageEnable(stageEnable), .speed(speed));

   always #10 clk = ~clk;

   // ==================================================================
   // Reporting
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         badCount++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task summarize;
      $display("comparisons %0d mismatches %0d", compares, badCount);
      if (badCount == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : summarize

   // Hang guard, far above the expected run length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         badCount++;
         summarize();
      end
   end

   // ==================================================================
   // Parameter access: request held one cycle, answer sampled after it
   task automatic prm(input logic wr, input logic [15:0] a, input logic [31:0] d,
                      input logic [31:0] expD, input logic expErr);
      @(posedge clk);
      req.wr <= wr;
      req.rd <= !wr;
      req.addr <= a;
      req.wdata <= d;
      @(posedge clk);
      req <= '0;
      #1;
      chk("ack", 32'h1, {31'h0, rsp.ack});
      chk("err", {31'h0, expErr}, {31'h0, rsp.err});
      if (!wr) chk("rdata", expD, rsp.rdata);
   endtask : prm

   task automatic waitHi(input string nm, ref logic s, input int lim);
      int n;
      n = 0;
      while (s !== 1'b1 && n < lim) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(nm, 32'h1, {31'h0, s});
   endtask : waitHi

   // One full halt: request, brake, hold, release, resume
   task automatic haltCycle(input logic h, input logic p, input logic ramp, input logic early);
      @(posedge clk);
      haltHost <= h;
      haltPin <= p;
      waitHi("haltActive", haltActive, 6);
      chk("brakeRamp", {31'h0, ramp}, {31'h0, brakeRamp});
      chk("brakeCurrent", {31'h0, !ramp}, {31'h0, brakeCurrent});
      chk("currentLimitOn", {31'h0, !ramp}, {31'h0, currentLimitOn});
      if (early) begin
         @(posedge clk);
         haltHost <= 1'b0;
         haltPin <= 1'b0;
         repeat (4) @(posedge clk);
         #1;
         chk("stillBraking", 32'h1, {31'h0, brakeRamp | brakeCurrent});
         chk("earlyResume", 32'h0, {31'h0, moveResume});
      end
      waitHi("posAdjust", posAdjust, 400);
      chk("posHold", 32'h1, {31'h0, posHold});
      chk("stageHold", 32'h1, {31'h0, stageEnable});
      // Requests already gone resume straight after the adjust pulse
      @(posedge clk);
      haltHost <= 1'b0;
      #1;
      chk("resumeTiming", {31'h0, early}, {31'h0, moveResume});
      @(posedge clk);
      #1;
      chk("otherSource", {31'h0, p & !early}, {31'h0, posHold});
      if (p && !early) begin
         repeat (6) @(posedge clk);
         #1;
         chk("pinHolds", 32'h1, {31'h0, posHold});
         @(posedge clk);
         haltPin <= 1'b0;
         waitHi("moveResume", moveResume, 8);
      end else begin
         chk("moveResume", {31'h0, !early}, {31'h0, moveResume});
      end
      repeat (3) @(posedge clk);
   endtask : haltCycle

   // ==================================================================
   // Main sequence
   initial begin
      req = '0;
      {haltHost, haltPin, profileMode, modeEnding, dcBusOverPin, faultClear} = '0;
      void'($urandom(78));
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      prm(1'b0, ADDR_HALTTYPE, 32'h0, {16'h0, HALTTYPE_RST}, 1'b0);
      prm(1'b0, ADDR_DECEL, 32'h0, DECEL_RST, 1'b0);
      chk("stageReset", 32'h1, {31'h0, stageEnable});
      $display("test reset done");
      // Refused writes keep the old setting
      badTypes = '{16'h0000, 16'h0002, 16'h0004, 16'($urandom) | 16'h0100};
      foreach (badTypes[i]) prm(1'b1, ADDR_HALTTYPE, {16'h0, badTypes[i]}, 32'h0, 1'b1);
      prm(1'b0, ADDR_HALTTYPE, 32'h0, {16'h0, TYPE_CURRENT}, 1'b0);
      prm(1'b1, ADDR_DECEL, DECEL_MIN - 32'h1, 32'h0, 1'b1);
      prm(1'b1, ADDR_DECEL, DECEL_MAX + 32'h1, 32'h0, 1'b1);
      prm(1'b0, ADDR_DECEL, 32'h0, DECEL_RST, 1'b0);
      prm(1'b0, 16'h0700, 32'h0, 32'h0, 1'b1);
      $display("test refusals done");
      haltCycle(1'b1, 1'b0, 1'b0, 1'b0);
      $display("test current halt done");
      dec = DECEL_MIN + ($urandom % (DECEL_MAX - DECEL_MIN + 32'h1));
      prm(1'b1, ADDR_DECEL, dec, 32'h0, 1'b0);
      prm(1'b1, ADDR_HALTTYPE, {16'h0, TYPE_RAMP}, 32'h0, 1'b0);
      chk("decelSetpoint", dec, decelSetpoint);
      @(posedge clk);
      profileMode <= 1'b1;
      haltCycle(1'b1, 1'b1, 1'b1, 1'b0);
      haltCycle(1'b0, 1'b1, 1'b1, 1'b1);
      $display("test ramp halt done");
      profileMode <= 1'b0;
      haltCycle(1'b1, 1'b0, 1'b0, 1'b1);
      $display("test no profile done");
      cl = {16'h0, 16'($urandom)};
      prm(1'b1, ADDR_CURLIM, cl, 32'h0, 1'b0);
      prm(1'b0, ADDR_CURLIM, 32'h0, cl, 1'b0);
      @(posedge clk);
      modeEnding <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk("modeEndLimitOn", 32'h1, {31'h0, currentLimitOn});
      chk("currentLimit", cl, {16'h0, currentLimit});
      $display("test mode end done");
      // Overvoltage while braking
      @(posedge clk);
      modeEnding <= 1'b0;
      haltHost <= 1'b1;
      waitHi("haltActive", haltActive, 6);
      @(posedge clk);
      dcBusOverPin <= 1'b1;
      waitHi("dcBusOverErr", dcBusOverErr, 6);
      chk("stageOff", 32'h0, {31'h0, stageEnable});
      @(posedge clk);
      haltHost <= 1'b0;
      dcBusOverPin <= 1'b0;
      repeat (4) @(posedge clk);
      faultClear <= 1'b1;
      @(posedge clk);
      faultClear <= 1'b0;
      waitHi("stageBack", stageEnable, 6);
      chk("errCleared", 32'h0, {31'h0, dcBusOverErr});
      $display("test overvoltage done");
      summarize();
   end

endmodule : testbench
